// *** include/cgr_bank_if.sv ***
/*
  Carrier between the register file top and one bank of word storage:
  per word byte enables, write data and the stored words.
  Assumes the top drives the enables only for the selected bank.
*/
`timescale 1ns/1ps
interface cgr_bank_if;

  logic [cgr_pkg::NUM_REGS-1:0][1:0]                 be;
  logic [cgr_pkg::NUM_REGS-1:0][cgr_pkg::WORD_W-1:0] wd;
  logic [cgr_pkg::NUM_REGS-1:0][cgr_pkg::WORD_W-1:0] q;

  modport ctrl
  (
    output be,
    output wd,
    input  q
  );

  modport store
  (
    input  be,
    input  wd,
    output q
  );

endinterface

// *** include/cgr_pkg.sv ***
/*
  Shared constants for the cpu general register file: widths, register
  indices, register bus addresses, reset values and vector table layout.
  Assumes every user refers to names as cgr_pkg::name.
*/
package cgr_pkg;

  localparam int unsigned WORD_W   = 16;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned BUS_W    = 32;
  localparam int unsigned VTB_W    = 20;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned NUM_REGS = 7;
  localparam int unsigned VNUM_W   = 6;

  // word index inside one bank
  localparam int unsigned IDX_D0 = 0;
  localparam int unsigned IDX_D1 = 1;
  localparam int unsigned IDX_D2 = 2;
  localparam int unsigned IDX_D3 = 3;
  localparam int unsigned IDX_A0 = 4;
  localparam int unsigned IDX_A1 = 5;
  localparam int unsigned IDX_FB = 6;

  // register port addresses
  localparam logic [ADDR_W-1:0] ADR_DATA_ZERO  = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_DATA_ONE   = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_DATA_TWO   = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_DATA_THREE = 4'h3;
  localparam logic [ADDR_W-1:0] ADR_ZERO_HIGH  = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_ZERO_LOW   = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_ONE_HIGH   = 4'h6;
  localparam logic [ADDR_W-1:0] ADR_ONE_LOW    = 4'h7;
  localparam logic [ADDR_W-1:0] ADR_PAIR_LOWER = 4'h8;
  localparam logic [ADDR_W-1:0] ADR_PAIR_UPPER = 4'h9;
  localparam logic [ADDR_W-1:0] ADR_ADDR_ZERO  = 4'ha;
  localparam logic [ADDR_W-1:0] ADR_ADDR_ONE   = 4'hb;
  localparam logic [ADDR_W-1:0] ADR_ADDR_PAIR  = 4'hc;
  localparam logic [ADDR_W-1:0] ADR_FRAME      = 4'hd;
  localparam logic [ADDR_W-1:0] ADR_VECTOR     = 4'he;
  localparam logic [ADDR_W-1:0] ADR_BANK_CTRL  = 4'hf;

  // bank control field
  localparam int unsigned BANK_BIT = 0;

  // reset values
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [VTB_W-1:0]  VTB_RST  = 20'h00000;
  localparam logic              BANK_RST = 1'b0;
  localparam logic [BUS_W-1:0]  BUS_ZERO = 32'h00000000;

  // each vector entry is four bytes
  localparam int unsigned VEC_SHIFT = 2;

  typedef logic [1:0] cgr_be_type;

endpackage

// *** logic/cgr_bank.sv ***
/*
  One register bank: data, address and frame words, byte writable.
  Assumes write enables come from logic on core_clk, already gated by
  the clock enable and the bank select.
*/
`timescale 1ns/1ps
module cgr_bank
(
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  input  wire logic  clk_en,
  cgr_bank_if.store  bk
);

  logic [cgr_pkg::NUM_REGS-1:0][cgr_pkg::WORD_W-1:0] word_reg;

  assign bk.q = word_reg;

  // byte lanes update independently so views alias the same bits
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < cgr_pkg::NUM_REGS; i++)
      begin
        word_reg[i] <= cgr_pkg::WORD_RST;
      end
    end
    else if (clk_en)
    begin
      for (int i = 0; i < cgr_pkg::NUM_REGS; i++)
      begin
        for (int b = 0; b < 2; b++)
        begin
          if (bk.be[i][b])
          begin
            word_reg[i][b*cgr_pkg::BYTE_W +: cgr_pkg::BYTE_W] <=
              bk.wd[i][b*cgr_pkg::BYTE_W +: cgr_pkg::BYTE_W];
          end
        end
      end
    end
  end

endmodule

// *** logic/cgr_regfile.sv ***
/*
  General register file of a 16-bit cpu core: two banks of four data
  words, two address words and a frame base, plus a vector table base.
  Assumes a same-clock datapath master on the plain register port and
  on the vector request, one strobe per cycle, read data one cycle later.
*/
// Notes on behaviour
// - four 16-bit data words, each readable and writable as operand
// - first two data words also reachable as separate high and low bytes
// - third over first and fourth over second form two 32-bit words
// - two 16-bit address words, operands and bases for indirect addressing
// - second address word over first forms one 32-bit address word
// - 16-bit frame base word supplies base for frame-relative addressing
// - 20-bit vector table base; vector fetch addresses built on it
// - bank flag zero selects bank zero, one selects bank one
`timescale 1ns/1ps
module cgr_regfile
(
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic [cgr_pkg::ADDR_W-1:0]    bus_addr,
  input  wire logic [cgr_pkg::BUS_W-1:0]     bus_wdata,
  input  wire logic                          bus_wr,
  input  wire logic                          bus_rd,
  output wire logic [cgr_pkg::BUS_W-1:0]     bus_rdata,
  input  wire logic                          vec_req,
  input  wire logic [cgr_pkg::VNUM_W-1:0]    vec_num,
  output wire logic [cgr_pkg::VTB_W-1:0]     vec_addr,
  output wire logic                          vec_valid,
  output wire logic [cgr_pkg::WORD_W-1:0]    addr_base_zero,
  output wire logic [cgr_pkg::WORD_W-1:0]    addr_base_one,
  output wire logic [cgr_pkg::WORD_W-1:0]    frame_base,
  output wire logic                          bank_sel
);

  localparam int unsigned W  = cgr_pkg::WORD_W;
  localparam int unsigned BW = cgr_pkg::BYTE_W;
  localparam int unsigned N  = cgr_pkg::NUM_REGS;

  cgr_bank_if bank_zero_if ();
  cgr_bank_if bank_one_if ();

  logic [cgr_pkg::BUS_W-1:0]  rdata_reg;
  logic [cgr_pkg::VTB_W-1:0]  vtb_reg;
  logic                       bank_reg;
  logic [cgr_pkg::VTB_W-1:0]  vec_addr_reg;
  logic                       vec_valid_reg;
  logic [W-1:0]               base_zero_reg;
  logic [W-1:0]               base_one_reg;
  logic [W-1:0]               frame_reg;

  // byte lane enables from full, high-only and low-only hits
  function automatic cgr_pkg::cgr_be_type lane_be
  (
    input logic full,
    input logic hi,
    input logic lo
  );
    lane_be = {full | hi, full | lo};
  endfunction

  // a 32-bit view is the upper word concatenated above the lower word
  function automatic logic [cgr_pkg::BUS_W-1:0] pair_of
  (
    input logic [W-1:0] upper,
    input logic [W-1:0] lower
  );
    pair_of = {upper, lower};
  endfunction

  // zero-extend a 16-bit word onto the bus
  function automatic logic [cgr_pkg::BUS_W-1:0] word_of
  (
    input logic [W-1:0] val
  );
    word_of = {{(cgr_pkg::BUS_W-W){1'b0}}, val};
  endfunction

  // zero-extend one byte onto the bus
  function automatic logic [cgr_pkg::BUS_W-1:0] byte_of
  (
    input logic [BW-1:0] val
  );
    byte_of = {{(cgr_pkg::BUS_W-BW){1'b0}}, val};
  endfunction

  // write strobe taken at one register address
  function automatic logic wr_hit
  (
    input logic                       go,
    input logic [cgr_pkg::ADDR_W-1:0] a,
    input logic [cgr_pkg::ADDR_W-1:0] at
  );
    wr_hit = go & (a == at);
  endfunction

  // base plus four bytes per vector number, wrapping at the top
  function automatic logic [cgr_pkg::VTB_W-1:0] vec_entry
  (
    input logic [cgr_pkg::VTB_W-1:0]  base,
    input logic [cgr_pkg::VNUM_W-1:0] num
  );
    logic [cgr_pkg::VTB_W-1:0] off;
    off = {{(cgr_pkg::VTB_W-cgr_pkg::VNUM_W-cgr_pkg::VEC_SHIFT){1'b0}},
           num, {cgr_pkg::VEC_SHIFT{1'b0}}};
    vec_entry = base + off;
  endfunction

  // write decode
  wire wr_go = clk_en & bus_wr;

  wire hit_d0   = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_DATA_ZERO);
  wire hit_d1   = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_DATA_ONE);
  wire hit_d2   = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_DATA_TWO);
  wire hit_d3   = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_DATA_THREE);
  wire hit_d0h  = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_ZERO_HIGH);
  wire hit_d0l  = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_ZERO_LOW);
  wire hit_d1h  = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_ONE_HIGH);
  wire hit_d1l  = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_ONE_LOW);
  wire hit_p_lo = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_PAIR_LOWER);
  wire hit_p_up = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_PAIR_UPPER);
  wire hit_a0   = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_ADDR_ZERO);
  wire hit_a1   = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_ADDR_ONE);
  wire hit_ap   = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_ADDR_PAIR);
  wire hit_fb   = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_FRAME);
  wire hit_vtb  = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_VECTOR);
  wire hit_bank = wr_hit(wr_go, bus_addr, cgr_pkg::ADR_BANK_CTRL);

  wire [W-1:0] wd_lower = bus_wdata[W-1:0];
  wire [W-1:0] wd_upper = bus_wdata[2*W-1:W];
  // byte writes take the low byte of the bus on either lane
  wire [W-1:0] wd_dup   = {bus_wdata[BW-1:0], bus_wdata[BW-1:0]};

  // per word enables and data, common to both banks
  logic [N-1:0][1:0]   be_all;
  logic [N-1:0][W-1:0] wd_all;

  // separate high and low byte writes
  assign be_all[cgr_pkg::IDX_D0] = lane_be(hit_d0 | hit_p_lo, hit_d0h, hit_d0l);
  assign be_all[cgr_pkg::IDX_D1] = lane_be(hit_d1 | hit_p_up, hit_d1h, hit_d1l);
  // pairs write upper word into third and fourth
  assign be_all[cgr_pkg::IDX_D2] = lane_be(hit_d2 | hit_p_lo, 1'b0, 1'b0);
  assign be_all[cgr_pkg::IDX_D3] = lane_be(hit_d3 | hit_p_up, 1'b0, 1'b0);
  assign be_all[cgr_pkg::IDX_A0] = lane_be(hit_a0 | hit_ap, 1'b0, 1'b0);
  assign be_all[cgr_pkg::IDX_A1] = lane_be(hit_a1 | hit_ap, 1'b0, 1'b0);
  assign be_all[cgr_pkg::IDX_FB] = lane_be(hit_fb, 1'b0, 1'b0);

  wire d0_byte = hit_d0h | hit_d0l;
  wire d1_byte = hit_d1h | hit_d1l;

  assign wd_all[cgr_pkg::IDX_D0] = d0_byte ? wd_dup : wd_lower;
  assign wd_all[cgr_pkg::IDX_D1] = d1_byte ? wd_dup : wd_lower;
  assign wd_all[cgr_pkg::IDX_D2] = hit_p_lo ? wd_upper : wd_lower;
  assign wd_all[cgr_pkg::IDX_D3] = hit_p_up ? wd_upper : wd_lower;
  assign wd_all[cgr_pkg::IDX_A0] = wd_lower;
  assign wd_all[cgr_pkg::IDX_A1] = hit_ap ? wd_upper : wd_lower;
  assign wd_all[cgr_pkg::IDX_FB] = wd_lower;

  // writes reach only the selected bank
  assign bank_zero_if.be = bank_reg ? '0 : be_all;
  assign bank_one_if.be  = bank_reg ? be_all : '0;
  assign bank_zero_if.wd = wd_all;
  assign bank_one_if.wd  = wd_all;

  cgr_bank u_bank_zero
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .bk       (bank_zero_if.store)
  );

  cgr_bank u_bank_one
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .bk       (bank_one_if.store)
  );

  // reads come from the selected bank
  wire [N-1:0][W-1:0] cur_q = bank_reg ? bank_one_if.q : bank_zero_if.q;

  wire [W-1:0] q_d0 = cur_q[cgr_pkg::IDX_D0];
  wire [W-1:0] q_d1 = cur_q[cgr_pkg::IDX_D1];
  wire [W-1:0] q_d2 = cur_q[cgr_pkg::IDX_D2];
  wire [W-1:0] q_d3 = cur_q[cgr_pkg::IDX_D3];
  wire [W-1:0] q_a0 = cur_q[cgr_pkg::IDX_A0];
  wire [W-1:0] q_a1 = cur_q[cgr_pkg::IDX_A1];
  wire [W-1:0] q_fb = cur_q[cgr_pkg::IDX_FB];

  // read view selection
  logic [cgr_pkg::BUS_W-1:0] rd_view;

  // every view but vector base and bank control reads the words of the selected bank
  always_comb
  begin
    rd_view = cgr_pkg::BUS_ZERO;
    unique case (bus_addr)
      cgr_pkg::ADR_DATA_ZERO:  rd_view = word_of(q_d0);
      cgr_pkg::ADR_DATA_ONE:   rd_view = word_of(q_d1);
      cgr_pkg::ADR_DATA_TWO:   rd_view = word_of(q_d2);
      cgr_pkg::ADR_DATA_THREE: rd_view = word_of(q_d3);
      cgr_pkg::ADR_ZERO_HIGH:  rd_view = byte_of(q_d0[W-1:BW]);
      cgr_pkg::ADR_ZERO_LOW:   rd_view = byte_of(q_d0[BW-1:0]);
      cgr_pkg::ADR_ONE_HIGH:   rd_view = byte_of(q_d1[W-1:BW]);
      cgr_pkg::ADR_ONE_LOW:    rd_view = byte_of(q_d1[BW-1:0]);
      cgr_pkg::ADR_PAIR_LOWER: rd_view = pair_of(q_d2, q_d0);
      cgr_pkg::ADR_PAIR_UPPER: rd_view = pair_of(q_d3, q_d1);
      cgr_pkg::ADR_ADDR_ZERO:  rd_view = word_of(q_a0);
      cgr_pkg::ADR_ADDR_ONE:   rd_view = word_of(q_a1);
      cgr_pkg::ADR_ADDR_PAIR:  rd_view = pair_of(q_a1, q_a0);
      cgr_pkg::ADR_FRAME:      rd_view = word_of(q_fb);
      cgr_pkg::ADR_VECTOR:
        rd_view = {{(cgr_pkg::BUS_W-cgr_pkg::VTB_W){1'b0}}, vtb_reg};
      cgr_pkg::ADR_BANK_CTRL:
        rd_view = {{(cgr_pkg::BUS_W-1){1'b0}}, bank_reg};
    endcase
  end

  // read data stand from the cycle after the strobe until the next enabled cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= cgr_pkg::BUS_ZERO;
    else if (clk_en)
      rdata_reg <= bus_rd ? rd_view : cgr_pkg::BUS_ZERO;
  end

  // vector table base and bank flag
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vtb_reg  <= cgr_pkg::VTB_RST;
      bank_reg <= cgr_pkg::BANK_RST;
    end
    else if (clk_en)
    begin
      if (hit_vtb)
        vtb_reg <= bus_wdata[cgr_pkg::VTB_W-1:0];
      if (hit_bank)
        bank_reg <= bus_wdata[cgr_pkg::BANK_BIT];
    end
  end

  // vector entry address from base and vector number
  wire [cgr_pkg::VTB_W-1:0] vec_sum = vec_entry(vtb_reg, vec_num);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vec_addr_reg  <= cgr_pkg::VTB_RST;
      vec_valid_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      vec_valid_reg <= vec_req;
      if (vec_req)
        vec_addr_reg <= vec_sum;
    end
  end

  // address bases to the addressing unit
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_zero_reg <= cgr_pkg::WORD_RST;
      base_one_reg  <= cgr_pkg::WORD_RST;
    end
    else if (clk_en)
    begin
      base_zero_reg <= q_a0;
      base_one_reg  <= q_a1;
    end
  end

  // frame base to the addressing unit
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      frame_reg <= cgr_pkg::WORD_RST;
    else if (clk_en)
      frame_reg <= q_fb;
  end

  assign bus_rdata      = rdata_reg;
  assign vec_addr       = vec_addr_reg;
  assign vec_valid      = vec_valid_reg;
  assign addr_base_zero = base_zero_reg;
  assign addr_base_one  = base_one_reg;
  assign frame_base     = frame_reg;
  assign bank_sel       = bank_reg;

endmodule

// *** verif/cgr_dp_model.sv ***
/*
  Datapath side model: issues vector fetch requests one cycle after go.
  Assumes go and num are set by the bench at the rising edge.
*/
`timescale 1ns/1ps
module cgr_dp_model
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       go,
  input  wire logic [cgr_pkg::VNUM_W-1:0] num,
  output logic                            vec_req,
  output logic [cgr_pkg::VNUM_W-1:0]      vec_num
);
  // number is scrambled while no request stands
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vec_req <= 1'b0;
      vec_num <= '0;
    end
    else
    begin
      vec_req <= go;
      vec_num <= go ? num : ~vec_num;
    end
  end
endmodule

// *** verif/cgr_regfile_bench.sv ***
/*
  Self-checking bench for the cpu general register file.
  Assumes the design port contract: read data one cycle after the strobe.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module cgr_regfile_bench;
  logic        core_clk = 1'b0;
  logic        rst_n, clk_en, bus_wr, bus_rd, go;
  logic [3:0]  bus_addr;
  logic [31:0] bus_wdata;
  logic [5:0]  num, vec_num;
  logic        vec_req, vec_valid, bank_sel;
  logic [31:0] bus_rdata;
  logic [19:0] vec_addr;
  logic [15:0] addr_base_zero, addr_base_one, frame_base;
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;

  always #5 core_clk = ~core_clk;

  cgr_regfile dut_u (.core_clk, .rst_n, .clk_en, .bus_addr, .bus_wdata, .bus_wr,
    .bus_rd, .bus_rdata, .vec_req, .vec_num, .vec_addr, .vec_valid,
    .addr_base_zero, .addr_base_one, .frame_base, .bank_sel);
  cgr_dp_model dp_u (.core_clk, .rst_n, .go, .num, .vec_req, .vec_num);

  task end_of_test;
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      err_total++;
      end_of_test;
    end
  end

  task cyc(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_wr <= w;
    bus_rd <= r;
    bus_addr <= a;
    bus_wdata <= d;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    cyc(1'b0, 1'b1, a, 32'h0);
    cyc(1'b0, 1'b0, a, 32'h0);
    #1 `CHK("bus_rdata", e, bus_rdata)
  endtask

  task s_reset;
    for (int i = 0; i < 16; i++) rd(4'(i), 32'h0);
    `CHK("bank_sel", 1'b0, bank_sel)
  endtask

  task s_words;
    for (int i = 0; i < 4; i++)
    begin
      wr(4'(i), {16'hffff, 4'(i + 1), 12'h0ab});
      rd(4'(i), {16'h0000, 4'(i + 1), 12'h0ab});
    end
    wr(cgr_pkg::ADR_ADDR_ZERO, 32'h0000a0a0);
    wr(cgr_pkg::ADR_ADDR_ONE, 32'h0000b1b1);
    wr(cgr_pkg::ADR_FRAME, 32'h00007e57);
    rd(cgr_pkg::ADR_ADDR_ONE, 32'h0000b1b1);
    rd(cgr_pkg::ADR_FRAME, 32'h00007e57);
    `CHK("addr_base_zero", 16'ha0a0, addr_base_zero)
    `CHK("frame_base", 16'h7e57, frame_base)
  endtask

  task s_views;
    wr(cgr_pkg::ADR_ZERO_HIGH, 32'hffffffab);
    wr(cgr_pkg::ADR_ZERO_LOW, 32'h000000cd);
    rd(cgr_pkg::ADR_DATA_ZERO, 32'h0000abcd);
    rd(cgr_pkg::ADR_ZERO_HIGH, 32'h000000ab);
    wr(cgr_pkg::ADR_ONE_LOW, 32'h00000012);
    wr(cgr_pkg::ADR_ONE_HIGH, 32'h00000034);
    rd(cgr_pkg::ADR_DATA_ONE, 32'h00003412);
    wr(cgr_pkg::ADR_PAIR_LOWER, 32'h89abcdef);
    rd(cgr_pkg::ADR_PAIR_LOWER, 32'h89abcdef);
    rd(cgr_pkg::ADR_DATA_TWO, 32'h000089ab);
    rd(cgr_pkg::ADR_ZERO_LOW, 32'h000000ef);
    wr(cgr_pkg::ADR_DATA_THREE, 32'h00001357);
    rd(cgr_pkg::ADR_PAIR_UPPER, 32'h13573412);
    wr(cgr_pkg::ADR_ONE_HIGH, 32'h00000056);
    rd(cgr_pkg::ADR_DATA_ONE, 32'h00005612);
    wr(cgr_pkg::ADR_PAIR_UPPER, 32'h2468ace0);
    rd(cgr_pkg::ADR_DATA_THREE, 32'h00002468);
    rd(cgr_pkg::ADR_DATA_ONE, 32'h0000ace0);
    wr(cgr_pkg::ADR_ADDR_PAIR, 32'hcafe0bad);
    rd(cgr_pkg::ADR_ADDR_ONE, 32'h0000cafe);
    rd(cgr_pkg::ADR_ADDR_PAIR, 32'hcafe0bad);
    `CHK("addr_base_one", 16'hcafe, addr_base_one)
  endtask

  task s_bank;
    wr(cgr_pkg::ADR_BANK_CTRL, 32'h00000001);
    wr(cgr_pkg::ADR_DATA_ZERO, 32'h00005a5a);
    // strobe while frozen must be ignored
    wr(cgr_pkg::ADR_DATA_ZERO, 32'h0000dead);
    clk_en <= 1'b0;
    cyc(1'b0, 1'b0, 4'h0, 32'h0);
    clk_en <= 1'b1;
    rd(cgr_pkg::ADR_DATA_ZERO, 32'h00005a5a);
    rd(cgr_pkg::ADR_BANK_CTRL, 32'h00000001);
    `CHK("bank_sel", 1'b1, bank_sel)
    `CHK("addr_base_zero", 16'h0000, addr_base_zero)
    wr(cgr_pkg::ADR_BANK_CTRL, 32'h00000000);
    rd(cgr_pkg::ADR_DATA_ZERO, 32'h0000cdef);
    `CHK("addr_base_zero", 16'h0bad, addr_base_zero)
  endtask

  task s_vec;
    wr(cgr_pkg::ADR_VECTOR, 32'hfff00000);
    wr(cgr_pkg::ADR_VECTOR, 32'h000fffff);
    rd(cgr_pkg::ADR_VECTOR, 32'h000fffff);
    @(posedge core_clk);
    go <= 1'b1;
    num <= 6'h00;
    @(posedge core_clk);
    num <= 6'h01;
    @(posedge core_clk);
    go <= 1'b0;
    #1 `CHK("vec_addr", 20'hfffff, vec_addr)
    `CHK("vec_valid", 1'b1, vec_valid)
    @(posedge core_clk);
    #1 `CHK("vec_addr", 20'h00003, vec_addr)
    @(posedge core_clk);
    #1 `CHK("vec_valid", 1'b0, vec_valid)
  endtask

  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 4'h0;
    bus_wdata = 32'h0;
    go = 1'b0;
    num = 6'h00;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    s_reset;
    s_words;
    s_views;
    s_bank;
    s_vec;
    end_of_test;
  end
endmodule

// *** verif/cgr_regfile_monitor.sv ***
/*
  Port checker for the cpu general register file.
  Assumes one clock core_clk and reset rst_n, attached by bind.
*/
`timescale 1ns/1ps
module cgr_regfile_monitor
(
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  input wire logic                       clk_en,
  input wire logic [cgr_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [cgr_pkg::BUS_W-1:0]  bus_wdata,
  input wire logic                       bus_wr,
  input wire logic                       bus_rd,
  input wire logic [cgr_pkg::BUS_W-1:0]  bus_rdata,
  input wire logic                       vec_req,
  input wire logic [cgr_pkg::VNUM_W-1:0] vec_num,
  input wire logic [cgr_pkg::VTB_W-1:0]  vec_addr,
  input wire logic                       vec_valid,
  input wire logic [cgr_pkg::WORD_W-1:0] addr_base_zero,
  input wire logic [cgr_pkg::WORD_W-1:0] addr_base_one,
  input wire logic [cgr_pkg::WORD_W-1:0] frame_base,
  input wire logic                       bank_sel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  rd_idle_a:
  assert property (clk_en && !bus_rd |=> bus_rdata == cgr_pkg::BUS_ZERO)
    else $error("read data not zero outside answer");
  word_rw_a:
  assert property ((clk_en && bus_wr && bus_addr == cgr_pkg::ADR_DATA_ZERO) ##1
    (clk_en && bus_rd && bus_addr == cgr_pkg::ADR_DATA_ZERO)
    |=> bus_rdata == {16'h0000, $past(bus_wdata[15:0], 2)})
    else $error("data word readback wrong");
  byte_alias_a:
  assert property ((clk_en && bus_wr && bus_addr == cgr_pkg::ADR_ZERO_LOW) ##1
    (clk_en && bus_rd && bus_addr == cgr_pkg::ADR_DATA_ZERO)
    |=> bus_rdata[7:0] == $past(bus_wdata[7:0], 2))
    else $error("low byte not seen in word");
  pair_rw_a:
  assert property ((clk_en && bus_wr && bus_addr == cgr_pkg::ADR_PAIR_LOWER) ##1
    (clk_en && bus_rd && bus_addr == cgr_pkg::ADR_PAIR_LOWER)
    |=> bus_rdata == $past(bus_wdata, 2))
    else $error("data pair readback wrong");
  addr_pair_a:
  assert property (clk_en && bus_wr && bus_addr == cgr_pkg::ADR_ADDR_PAIR ##1 clk_en
    |=> {addr_base_one, addr_base_zero} == $past(bus_wdata, 2))
    else $error("address bases not from pair write");
  frame_out_a:
  assert property (clk_en && bus_wr && bus_addr == cgr_pkg::ADR_FRAME ##1 clk_en
    |=> frame_base == $past(bus_wdata[15:0], 2))
    else $error("frame base output wrong");
  bank_flag_a:
  assert property (clk_en && bus_wr && bus_addr == cgr_pkg::ADR_BANK_CTRL
    |=> bank_sel == $past(bus_wdata[0]))
    else $error("bank select not updated");
  vec_pulse_a:
  assert property (clk_en |=> vec_valid == $past(vec_req))
    else $error("vector valid not one cycle after request");
  vec_hold_a:
  assert property (clk_en && !vec_req |=> $stable(vec_addr))
    else $error("vector address moved without request");
  vec_step_a:
  assert property ((clk_en && vec_req && !bus_wr) ##1 (clk_en && vec_req && !bus_wr)
    |=> vec_addr == $past(vec_addr) + 20'({$past(vec_num), 2'b00})
      - 20'({$past(vec_num, 2), 2'b00}))
    else $error("vector address step not four per number");
endmodule
bind cgr_regfile cgr_regfile_monitor mon_u (.core_clk, .rst_n, .clk_en, .bus_addr,
  .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .vec_req, .vec_num, .vec_addr,
  .vec_valid, .addr_base_zero, .addr_base_one, .frame_base, .bank_sel);
